// ### logic/dsdo_top.sv
// Digital position outputs: pulse width, start/stop, quadrature and serial shift-out
`timescale 1ns/1ps

module dsdo_top #(
    parameter int POS_W = dsdo_pkg::POS_W,
    parameter int SSI_TIMEOUT_CYC = dsdo_pkg::SSI_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration straps, sampled each cycle
    input wire logic [1:0] outMode,
    input wire logic intInterrogate,
    input wire logic [1:0] ssiLenSel,
    // Measured position, proportional to magnet distance
    input wire logic [POS_W-1:0] position,
    input wire logic posValid,
    output logic posReady,
    // Interrogation start input from the controller
    input wire logic startIn,
    // Pulse timing output, positive and negative wires
    output logic timeOutP,
    output logic timeOutN,
    // Quadrature channels as pairs
    output logic quadAP,
    output logic quadAN,
    output logic quadBP,
    output logic quadBN,
    output logic quadZP,
    output logic quadZN,
    // Serial link from the controller
    input wire logic ssiClk,
    output logic ssiData
);
    //////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins from outside the clock domain
    logic [1:0] startSync_ff;
    logic [1:0] ssiClkSync_ff;
    logic startDly_ff;
    logic ssiClkDly_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            startSync_ff <= 2'h0;
            ssiClkSync_ff <= 2'h3;
            startDly_ff <= 1'b0;
            ssiClkDly_ff <= 1'b1;
        end else begin
            startSync_ff <= {startSync_ff[0], startIn};
            ssiClkSync_ff <= {ssiClkSync_ff[0], ssiClk};
            startDly_ff <= startSync_ff[1];
            ssiClkDly_ff <= ssiClkSync_ff[1];
        end
    end
    wire startRise = startSync_ff[1] & ~startDly_ff;
    wire ssiFall = ~ssiClkSync_ff[1] & ssiClkDly_ff;
    wire ssiRise = ssiClkSync_ff[1] & ~ssiClkDly_ff;

    //////////////////////////////////////////////////////////////////////////
    // Two-entry position buffer; a stalled consumer holds the word, none lost
    logic [POS_W-1:0] buf_ff [2];
    logic [1:0] bufCnt_ff;
    logic bufRd_ff;
    logic bufWr_ff;
    logic [POS_W-1:0] posHeld_ff;
    wire bufFull = (bufCnt_ff == 2'h2);
    wire bufEmpty = (bufCnt_ff == 2'h0);
    wire pushEn = posValid & ~bufFull;
    // Consumer drains only while no output is mid-measurement, so it can stall
    logic consumerBusy;
    logic ssiActive_ff;
    wire popEn = ~bufEmpty & ~consumerBusy;
    always_ff @(posedge clk) begin
        if (rst) begin
            bufCnt_ff <= 2'h0;
            bufRd_ff <= 1'b0;
            bufWr_ff <= 1'b0;
            posHeld_ff <= '0;
            posReady <= 1'b0;
        end else begin
            if (pushEn) begin
                buf_ff[bufWr_ff] <= position;
                bufWr_ff <= ~bufWr_ff;
            end
            if (popEn) begin
                posHeld_ff <= buf_ff[bufRd_ff];
                bufRd_ff <= ~bufRd_ff;
            end
            bufCnt_ff <= bufCnt_ff + {1'b0, pushEn} - {1'b0, popEn};
            posReady <= ~(bufCnt_ff == 2'h2 || (bufCnt_ff == 2'h1 && pushEn && !popEn));
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pulse timing sequencer for PWM and both start/stop modes
    localparam int CW = POS_W + 1;
    dsdo_pkg::dsdo_tstate_e tState_ff;
    logic [CW-1:0] tCnt_ff;
    logic [POS_W-1:0] tPos_ff;
    wire modePwm = (outMode == dsdo_pkg::MODE_PWM);
    wire modeDiff = (outMode == dsdo_pkg::MODE_SS_DIFF);
    wire trigExt = startRise & (tState_ff == dsdo_pkg::TS_IDLE);
    wire trigInt = modePwm & intInterrogate & (tState_ff == dsdo_pkg::TS_IDLE);
    wire trig = modePwm ? (intInterrogate ? trigInt : trigExt) : trigExt;
    wire tCntDone = (tCnt_ff == '0);
    localparam logic [CW-1:0] PULSE_CNT = CW'(dsdo_pkg::STOP_PULSE_CYC - 1);
    localparam logic [CW-1:0] GAP_CNT = CW'(dsdo_pkg::PWM_GAP_CYC - 1);
    // Start/stop modes are busy through the whole cycle; a start then is dropped
    assign consumerBusy = (tState_ff != dsdo_pkg::TS_IDLE) | ssiActive_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            tState_ff <= dsdo_pkg::TS_IDLE;
            tCnt_ff <= '0;
            tPos_ff <= '0;
            timeOutP <= 1'b0;
            timeOutN <= 1'b1;
        end else begin
            case (tState_ff)
                dsdo_pkg::TS_IDLE: begin
                    if (trig) begin
                        tPos_ff <= posHeld_ff;
                        if (modePwm) begin
                            tState_ff <= dsdo_pkg::TS_WIDTH;
                            tCnt_ff <= {1'b0, posHeld_ff};
                            timeOutP <= 1'b1;
                            timeOutN <= 1'b0;
                        end else if (modeDiff) begin
                            tState_ff <= dsdo_pkg::TS_START;
                            tCnt_ff <= PULSE_CNT;
                            timeOutP <= 1'b1;
                            timeOutN <= 1'b0;
                        end else begin
                            tState_ff <= dsdo_pkg::TS_WIDTH;
                            tCnt_ff <= {1'b0, posHeld_ff};
                        end
                    end
                end
                dsdo_pkg::TS_START: begin
                    tCnt_ff <= tCnt_ff - CW'(1);
                    if (tCntDone) begin
                        tState_ff <= dsdo_pkg::TS_WIDTH;
                        tCnt_ff <= {1'b0, tPos_ff};
                        timeOutP <= 1'b0;
                        timeOutN <= 1'b1;
                    end
                end
                dsdo_pkg::TS_WIDTH: begin
                    tCnt_ff <= tCnt_ff - CW'(1);
                    if (tCntDone) begin
                        if (modePwm) begin
                            tState_ff <= dsdo_pkg::TS_GAP;
                            tCnt_ff <= GAP_CNT;
                            timeOutP <= 1'b0;
                            timeOutN <= 1'b1;
                        end else begin
                            tState_ff <= dsdo_pkg::TS_STOP;
                            tCnt_ff <= PULSE_CNT;
                            timeOutP <= 1'b1;
                            timeOutN <= 1'b0;
                        end
                    end
                end
                dsdo_pkg::TS_STOP: begin
                    tCnt_ff <= tCnt_ff - CW'(1);
                    if (tCntDone) begin
                        tState_ff <= dsdo_pkg::TS_IDLE;
                        timeOutP <= 1'b0;
                        timeOutN <= 1'b1;
                    end
                end
                default: begin
                    // Recovery gap keeps internal pulses distinct
                    tCnt_ff <= tCnt_ff - CW'(1);
                    if (tCntDone) begin
                        tState_ff <= dsdo_pkg::TS_IDLE;
                    end
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Quadrature: an up/down tracker steps toward the held position
    logic [POS_W-1:0] qPos_ff;
    logic [1:0] qPhase_ff;
    logic [3:0] qDiv_ff;
    wire qTick = (qDiv_ff == 4'(dsdo_pkg::QUAD_STEP_CYC - 1));
    wire qUp = (posHeld_ff > qPos_ff);
    wire qDn = (posHeld_ff < qPos_ff);
    // Gray sequence 00,01,11,10 keeps A and B ninety degrees apart
    wire [1:0] qNxtUp = {qPhase_ff[0], ~qPhase_ff[1]};
    wire [1:0] qNxtDn = {~qPhase_ff[0], qPhase_ff[1]};
    wire [1:0] nxt_qPhase = qUp ? qNxtUp : (qDn ? qNxtDn : qPhase_ff);
    wire qStep = qTick & (qUp | qDn);
    always_ff @(posedge clk) begin
        if (rst) begin
            qPos_ff <= '0;
            qPhase_ff <= 2'h0;
            qDiv_ff <= 4'h0;
            {quadAP, quadAN, quadBP, quadBN, quadZP, quadZN} <= 6'h2A;
        end else begin
            qDiv_ff <= qTick ? 4'h0 : qDiv_ff + 4'h1;
            if (qStep) begin
                qPhase_ff <= nxt_qPhase;
                qPos_ff <= qUp ? qPos_ff + POS_W'(1) : qPos_ff - POS_W'(1);
            end
            // Logic 0 is positive wire high; each pair always complementary
            quadAP <= ~qPhase_ff[1];
            quadAN <= qPhase_ff[1];
            quadBP <= ~qPhase_ff[0];
            quadBN <= qPhase_ff[0];
            quadZP <= ~(qPos_ff == '0);
            quadZN <= (qPos_ff == '0);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Serial shift-out, MSB first, framed by the controller clock
    logic [POS_W-1:0] shReg_ff;
    logic [4:0] ssiBits_ff;
    logic [$clog2(SSI_TIMEOUT_CYC+1)-1:0] ssiTmo_ff;
    wire [4:0] ssiLen = (ssiLenSel == dsdo_pkg::LEN_24) ? 5'(dsdo_pkg::SSI_LEN_24) :
                        (ssiLenSel == dsdo_pkg::LEN_25) ? 5'(dsdo_pkg::SSI_LEN_25) :
                        5'(dsdo_pkg::SSI_LEN_26);
    // Left-align the chosen length so the MSB sits at the top
    wire [POS_W-1:0] ssiLoad = posHeld_ff << (5'(POS_W) - ssiLen);
    wire ssiTmoDone = (ssiTmo_ff == '0);
    always_ff @(posedge clk) begin
        if (rst) begin
            shReg_ff <= '0;
            ssiActive_ff <= 1'b0;
            ssiBits_ff <= 5'h0;
            ssiTmo_ff <= '0;
            ssiData <= 1'b1;
        end else if (!ssiActive_ff) begin
            ssiData <= 1'b1;
            if (ssiFall) begin
                // First falling edge latches a fresh word
                shReg_ff <= ssiLoad;
                ssiActive_ff <= 1'b1;
                ssiBits_ff <= 5'h0;
                ssiTmo_ff <= '0;
            end
        end else begin
            if (ssiRise) begin
                // One bit per clock pulse; zero after the word ends
                ssiData <= (ssiBits_ff < ssiLen) ? shReg_ff[POS_W-1] : 1'b0;
                shReg_ff <= {shReg_ff[POS_W-2:0], 1'b0};
                ssiBits_ff <= (ssiBits_ff == 5'h1F) ? ssiBits_ff : ssiBits_ff + 5'h1;
            end
            // Monoflop: restarts on each edge, ends frame when clock stays high
            if (ssiRise || ssiFall || !ssiClkSync_ff[1]) begin
                ssiTmo_ff <= ($bits(ssiTmo_ff))'(SSI_TIMEOUT_CYC);
            end else if (!ssiTmoDone) begin
                ssiTmo_ff <= ssiTmo_ff - ($bits(ssiTmo_ff))'(1);
            end else begin
                ssiActive_ff <= 1'b0;
                ssiData <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks on driven outputs and internal state (phase, sequencer, shift register, buffer count)
    AST_PAIR_COMPL: assert property (@(posedge clk) disable iff (rst)
        (quadAP != quadAN) && (quadBP != quadBN) && (quadZP != quadZN))
        else $error("Quadrature pair not complementary");
    AST_QUAD_ONE_STEP: assert property (@(posedge clk) disable iff (rst)
        $changed(qPhase_ff) |-> (qPhase_ff ^ $past(qPhase_ff)) != 2'h3)
        else $error("Quadrature jumped two steps");
    AST_PWM_LATENCY: assert property (@(posedge clk) disable iff (rst)
        trig && modePwm |=> timeOutP)
        else $error("Output pulse not started after start");
    AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (rst)
        (tState_ff == dsdo_pkg::TS_WIDTH) && startRise |=> tState_ff != dsdo_pkg::TS_IDLE)
        else $error("Start during busy cycle restarted it");
    AST_DIFF_PULSE: assert property (@(posedge clk) disable iff (rst)
        $rose(timeOutP) && !modePwm |-> timeOutP [*8])
        else $error("Start/stop pulse too short");
    AST_SSI_IDLE: assert property (@(posedge clk) disable iff (rst)
        !ssiActive_ff && !$past(ssiActive_ff) |-> ssiData)
        else $error("Serial data not idle high");
    AST_SSI_NOCLK: assert property (@(posedge clk) disable iff (rst)
        ssiActive_ff && !ssiRise && $past(ssiActive_ff) && !$fell(ssiActive_ff)
        |=> $stable(shReg_ff) || $past(ssiRise) || $past(ssiFall))
        else $error("Shift register moved without clock");
    AST_BUF_NOOVER: assert property (@(posedge clk) disable iff (rst)
        bufCnt_ff <= 2'h2)
        else $error("Position buffer overflow");
endmodule : dsdo_top

// ### shared/dsdo_pkg.sv
// Constants and types shared by the displacement sensor digital output block
package dsdo_pkg;
    // Clock rate and timing figures
    localparam int CLK_MHZ = 40;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STOP_PULSE_NS = 1000;
    localparam int STOP_PULSE_CYC = (STOP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_MIN_NS = 1000;
    localparam int START_MIN_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_LAT_NS = 50;
    localparam int START_LAT_CYC = START_LAT_NS / CLK_PERIOD_NS;
    localparam int SSI_TIMEOUT_NS = 20000;
    localparam int SSI_TIMEOUT_CYC = SSI_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int PWM_GAP_CYC = 40;
    localparam int QUAD_STEP_CYC = 8;
    // Position and serial word widths
    localparam int POS_W = 26;
    localparam int SSI_LEN_24 = 24;
    localparam int SSI_LEN_25 = 25;
    localparam int SSI_LEN_26 = 26;
    // Output mode select codes
    localparam logic [1:0] MODE_PWM = 2'h0;
    localparam logic [1:0] MODE_SS_DIFF = 2'h1;
    localparam logic [1:0] MODE_SS_TTL = 2'h2;
    // Serial length codes
    localparam logic [1:0] LEN_24 = 2'h0;
    localparam logic [1:0] LEN_25 = 2'h1;
    localparam logic [1:0] LEN_26 = 2'h2;
    // Timing-output sequencer states
    typedef enum logic [2:0] {
        TS_IDLE, TS_START, TS_WIDTH, TS_STOP, TS_GAP
    } dsdo_tstate_e;
endpackage : dsdo_pkg

// ### dv/dsdo_ctrl_model.sv
// Controller-side model: interrogation starts and serial clock bursts
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dsdo_ctrl_model (
    // Pins toward the sensor
    output logic startIn,
    output logic ssiClk,
    // Serial data from the sensor
    input wire logic ssiData
);
    // Start idles low, serial clock idles high and stands still between frames
    initial begin
        startIn = 1'b0;
        ssiClk = 1'b1;
    end
    // Start of 1.2 us, off the clock grid so that no edge races the sampler
    task automatic start_pulse();
        #7;
        startIn = 1'b1;
        #1200;
        startIn = 1'b0;
    endtask : start_pulse
    // Park the clock low to open a frame without shifting
    task automatic open_frame();
        #7;
        ssiClk = 1'b0;
    endtask : open_frame
    // Burst of len+1 periods at 200 ns; each bit is taken at the following rise
    task automatic read_word(input int len, output logic [31:0] w, output logic tail);
        w = 32'h0;
        #7;
        ssiClk = 1'b0;
        #100;
        for (int i = 0; i <= len; i++) begin
            ssiClk = 1'b1;
            if (i > 0) w = {w[30:0], ssiData};
            #100;
            if (i < len) begin
                ssiClk = 1'b0;
                #100;
            end
        end
        #100;
        tail = ssiData;
    endtask : read_word
endmodule : dsdo_ctrl_model

// ### dv/displacement_sensor_digital_outputs_bench.sv
// Self-checking bench for the digital position outputs
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module displacement_sensor_digital_outputs_bench;
    localparam int TMO = 20;
    localparam int STOP = dsdo_pkg::STOP_PULSE_CYC;
    logic clk, rst, intInterrogate, posValid, posReady, startIn, timeOutP, timeOutN;
    logic quadAP, quadAN, quadBP, quadBN, quadZP, quadZN, ssiClk, ssiData;
    logic [1:0] outMode, ssiLenSel, qIdx, qNow, qStep;
    logic [dsdo_pkg::POS_W-1:0] position;
    logic [15:0] rnd;
    int err_total, comparisons, qCount;
    // Shortened serial timeout keeps frame gaps brief
    dsdo_top #(.SSI_TIMEOUT_CYC(TMO)) uut (.clk(clk), .rst(rst), .outMode(outMode),
        .intInterrogate(intInterrogate), .ssiLenSel(ssiLenSel), .position(position),
        .posValid(posValid), .posReady(posReady), .startIn(startIn), .timeOutP(timeOutP),
        .timeOutN(timeOutN), .quadAP(quadAP), .quadAN(quadAN), .quadBP(quadBP),
        .quadBN(quadBN), .quadZP(quadZP), .quadZN(quadZN), .ssiClk(ssiClk),
        .ssiData(ssiData));
    dsdo_ctrl_model ctrl (.startIn(startIn), .ssiClk(ssiClk), .ssiData(ssiData));
    // 40 MHz clock
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic int slen(input int k);
        return (k == 0) ? 24 : (k == 1) ? 25 : 26;
    endfunction : slen
    // Word is the low len bits of the position, MSB first
    function automatic logic [31:0] ssi_exp(input logic [25:0] v, input int len);
        return 32'(v) & ((32'h1 << len) - 32'h1);
    endfunction : ssi_exp
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // Offer one word, hold it until taken, then let the consumer settle
    task automatic push(input logic [25:0] v, input int settle);
        int n;
        n = 0;
        @(posedge clk);
        position <= v;
        posValid <= 1'b1;
        @(posedge clk);
        while (posReady !== 1'b1 && n < 2000) begin
            n++;
            @(posedge clk);
        end
        if (n == 2000) chk(1'b0, "word never taken");
        posValid <= 1'b0;
        repeat (settle) @(posedge clk);
    endtask : push
    // Cycles low before a pulse, then cycles high
    task automatic meas(input int lim, output int w, output int h);
        w = 0;
        h = 0;
        while (timeOutP !== 1'b1 && w < lim) begin
            w++;
            @(posedge clk);
        end
        while (timeOutP === 1'b1 && h < 2000) begin
            h++;
            @(posedge clk);
        end
    endtask : meas
    ////////////////////////////////////////////////////////////////////////////
    // Quadrature decoder; a two-state jump would hide a lost count
    // B leads A while counting up, so logic A is the upper index bit
    assign qNow = {~quadAP, quadAP ^ quadBP};
    assign qStep = qNow - qIdx;
    always @(posedge clk) begin
        if (rst) begin
            qCount <= 0;
            qIdx <= 2'h0;
        end else begin
            chk(quadAP === ~quadAN && quadBP === ~quadBN && quadZP === ~quadZN, "pair");
            chk(timeOutP === ~timeOutN, "timing pair");
            chk(qStep !== 2'h2, "quad jump");
            if (qStep == 2'h1) qCount <= qCount + 1;
            else if (qStep == 2'h3) qCount <= qCount - 1;
            qIdx <= qNow;
        end
    end
    // Watchdog well beyond the expected run length
    initial begin
        #1500000;
        err_total++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int w, h, w2, h2, d0;
        logic [31:0] sw;
        logic tl;
        logic [25:0] v, held;
        rst = 1'b1;
        outMode = dsdo_pkg::MODE_PWM;
        intInterrogate = 1'b0;
        ssiLenSel = dsdo_pkg::LEN_24;
        position = 26'h0;
        posValid = 1'b0;
        rnd = 16'h003C;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(timeOutP === 1'b0 && quadAP === 1'b1 && ssiData === 1'b1, "idle levels");
        // Pulse width: external starts with a zero corner, then free running
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            v = (k == 0) ? 26'h0 : 26'(rnd[6:0]);
            push(v, 60);
            intInterrogate <= (k == 3);
            fork
                if (k < 3) ctrl.start_pulse();
                meas(2000, w, h);
            join
            chk(h == v + 1, "pulse width");
            if (k < 3) chk(w <= 6, "start latency");
        end
        meas(2000, w, h);
        chk(h == v + 1, "free running repeat");
        intInterrogate <= 1'b0;
        repeat (300) @(posedge clk);
        // Differential start/stop: two fixed pulses around a position-long gap
        outMode <= dsdo_pkg::MODE_SS_DIFF;
        rnd = lfsr_next(rnd);
        v = 26'(rnd[6:0]);
        push(v, 60);
        fork
            ctrl.start_pulse();
            begin
                meas(2000, w, h);
                meas(2000, w2, h2);
            end
        join
        chk(h == STOP && w2 == v + 1 && h2 == STOP, "differential pair");
        // Single-ended: one stop pulse; a start while busy must be ignored
        outMode <= dsdo_pkg::MODE_SS_TTL;
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr_next(rnd);
            v = 26'h64 + 26'(rnd[5:0]);
            push(v, 60);
            fork
                ctrl.start_pulse();
                begin
                    #1500;
                    ctrl.start_pulse();
                end
                meas(2000, w, h);
            join
            meas(150, w2, h2);
            chk(h == STOP && h2 == 0, "stop pulse");
            if (k == 0) d0 = w - int'(v);
            else chk(w - d0 == int'(v), "stop delay");
        end
        // Quadrature follows the held position, then back to zero with Z marked
        rnd = lfsr_next(rnd);
        v = 26'(rnd[7:0]);
        push(v, 2500);
        chk(qCount == int'(v), "quad count");
        push(26'h0, 2500);
        chk(qCount == 0 && quadZP === 1'b0, "zero marker");
        // Serial words at every length code
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            held = {rnd[9:0], rnd};
            ssiLenSel <= 2'(k);
            push(held, 60);
            ctrl.read_word(slen(k), sw, tl);
            chk(sw === ssi_exp(held, slen(k)) && tl === 1'b0, "serial word");
            #1000;
            chk(ssiData === 1'b1, "idle after timeout");
        end
        // Consumer stalled by an open frame: two words queue, then drain in order
        ctrl.open_frame();
        repeat (8) @(posedge clk);
        rnd = lfsr_next(rnd);
        v = {rnd, rnd[9:0]};
        push(~v, 0);
        push(v, 4);
        chk(posReady === 1'b0, "buffer full");
        ctrl.read_word(26, sw, tl);
        chk(sw === ssi_exp(held, 26), "frame keeps word");
        #1000;
        repeat (20) @(posedge clk);
        ctrl.read_word(26, sw, tl);
        chk(sw === ssi_exp(v, 26), "last queued word");
        tally_and_finish();
    end
endmodule : displacement_sensor_digital_outputs_bench
